// ===== hw/rda_flags.sv
// Zero, negative and positive condition flags with optional accumulation
`timescale 1ns/1ns
module rda_flags
    import rda_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     ce,
    input  wire logic     upd,
    input  wire logic     acc,
    input  rda_res_t      res,
    output logic          zero_f,
    output logic          neg_f,
    output logic          pos_f
);
    wire r_ok  = (res == RES_OK);
    wire r_neg = (res == RES_NEG);
    wire r_pos = (res == RES_POS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_f <= 1'b0;
            neg_f  <= 1'b0;
            pos_f  <= 1'b0;
        end else if (ce && upd) begin
            // Zero survives a series only while every command succeeded
            zero_f <= acc ? (zero_f && r_ok) : r_ok;
            neg_f  <= acc ? (neg_f || r_neg) : r_neg;
            pos_f  <= acc ? (pos_f || r_pos) : r_pos;
        end
    end
endmodule

// ===== hw/rda_pkg.sv
// Shared constants and types for the remote dictionary access engine
package rda_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_TIME_US  = 120;
    localparam int unsigned TICK_CYCLES   = (TICK_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;

    localparam logic [11:0] OFS_CMD       = 12'h000;
    localparam logic [11:0] OFS_DATA      = 12'h004;
    localparam logic [11:0] OFS_ENTRY     = 12'h008;
    localparam logic [11:0] OFS_COUNT     = 12'h00C;
    localparam logic [11:0] OFS_TIMEOUT   = 12'h010;
    localparam logic [11:0] OFS_STATUS    = 12'h014;
    localparam logic [11:0] OFS_USER_BASE = 12'h100;

    localparam logic [31:0] CMD_RST       = 32'h0000_0010;
    localparam logic [31:0] CMD_MASK      = 32'h0000_0037;
    localparam logic [31:0] DATA_RST      = 32'h0000_0000;
    localparam logic [31:0] ENTRY_RST     = 32'h0000_0000;
    localparam logic [15:0] COUNT_RST     = 16'h0004;
    localparam logic [15:0] TIMEOUT_RST   = 16'h0028;

    localparam int unsigned CMD_GO_BIT     = 31;
    localparam int unsigned CMD_ACC_BIT    = 2;
    localparam int unsigned CMD_CLIENT_LSB = 4;
    localparam int unsigned ENTRY_SUB_LSB  = 16;
    localparam int unsigned COUNT_NOLIM_BIT = 15;

    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_ZERO_BIT = 1;
    localparam int unsigned ST_NEG_BIT  = 2;
    localparam int unsigned ST_POS_BIT  = 3;
    localparam int unsigned ST_OVF_BIT  = 4;
    localparam int unsigned ST_PTR_LSB  = 16;

    localparam logic [1:0]  MODE_UPLOAD   = 2'h0;
    localparam logic [1:0]  MODE_DL_REG   = 2'h1;
    localparam logic [1:0]  MODE_DL_CONST = 2'h2;
    localparam logic [1:0]  CLIENT_ONE    = 2'h1;
    localparam logic [1:0]  CLIENT_TWO    = 2'h2;
    localparam logic [14:0] CONST_MAX_BYTES = 15'h0004;

    typedef enum logic [1:0] {
        RES_OK  = 2'b00,
        RES_NEG = 2'b01,
        RES_POS = 2'b10
    } rda_res_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_XFER = 1'b1
    } rda_state_t;

endpackage

// ===== hw/rda_tick.sv
// Fixed-period tick prescaler, restartable so a wait starts on a tick boundary
`timescale 1ns/1ns
module rda_tick
    import rda_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

    logic [CW-1:0] cnt_reg;
    wire           wrap = (cnt_reg == LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else if (ce) begin
            cnt_reg <= (restart || wrap) ? '0 : cnt_reg + CW'(1);
            tick    <= wrap && !restart;
        end
    end
endmodule

// ===== hw/rda_top.sv
// Remote dictionary access engine: APB registers, SDO client requests, result flags
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
module rda_top
    import rda_pkg::*;
#(
    parameter int unsigned NREG  = 16,
    parameter int unsigned TICKS = TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sdo_req,
    output logic             sdo_client,
    output logic             sdo_upload,
    output logic      [15:0] sdo_index,
    output logic      [7:0]  sdo_subindex,
    output logic      [14:0] sdo_size,
    output logic             dl_valid,
    output logic      [7:0]  dl_byte,
    input  wire logic        dl_ready,
    input  wire logic        ul_valid,
    input  wire logic [7:0]  ul_byte,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_abort,
    output logic             cond_zero,
    output logic             cond_neg,
    output logic             cond_pos
);
    localparam int unsigned IW = $clog2(NREG);
    localparam logic [11:0] USER_END = OFS_USER_BASE + 12'(NREG * 4);

    rda_state_t    st_reg;
    logic [31:0]   cmd_reg;
    logic [31:0]   data_reg;
    logic [31:0]   entry_reg;
    logic [15:0]   count_reg;
    logic [15:0]   timeout_reg;
    logic [15:0]   tmo_left_reg;
    logic [14:0]   ptr_reg;
    logic [14:0]   limit_reg;
    logic          ovf_reg;
    logic [31:0]   user_mem [NREG];
    logic          tick;

    // Bus decode
    wire        apb_done = psel && penable && pready;
    wire        apb_wr   = apb_done && pwrite;
    wire [11:0] ofs      = {paddr[11:2], 2'b00};
    wire        user_hit = (ofs >= OFS_USER_BASE) && (ofs < USER_END);
    wire [IW-1:0] user_idx = paddr[2 +: IW];
    wire        reg_hit  = (ofs == OFS_CMD) || (ofs == OFS_DATA) || (ofs == OFS_ENTRY)
                        || (ofs == OFS_COUNT) || (ofs == OFS_TIMEOUT)
                        || (ofs == OFS_STATUS);
    wire        map_err  = !(reg_hit || user_hit);
    wire        idle     = (st_reg == ST_IDLE);
    wire        xfer     = (st_reg == ST_XFER);

    wire [31:0] status_word = {1'b0, ptr_reg, 11'h000, ovf_reg, cond_pos, cond_neg,
                               cond_zero, xfer};
    wire [31:0] rd_word =
        (ofs == OFS_CMD)     ? cmd_reg :
        (ofs == OFS_DATA)    ? data_reg :
        (ofs == OFS_ENTRY)   ? entry_reg :
        (ofs == OFS_COUNT)   ? {16'h0000, count_reg} :
        (ofs == OFS_TIMEOUT) ? {16'h0000, timeout_reg} :
        (ofs == OFS_STATUS)  ? status_word :
        user_hit             ? user_mem[user_idx] : 32'h0000_0000;

    // Command launch; a go written while busy is ignored
    wire       go_wr     = apb_wr && (ofs == OFS_CMD) && pwdata[CMD_GO_BIT];
    wire       go        = go_wr && idle;
    wire [1:0] go_base   = pwdata[1:0];
    wire       go_acc    = pwdata[CMD_ACC_BIT];
    wire [1:0] go_client = pwdata[CMD_CLIENT_LSB +: 2];
    wire       go_bad    = (go_base == 2'h3)
                        || !((go_client == CLIENT_ONE) || (go_client == CLIENT_TWO));
    wire       go_start  = go && !go_bad;
    wire       go_const  = (go_base == MODE_DL_CONST);
    wire [14:0] cnt_bytes = count_reg[14:0];
    wire [14:0] go_limit = (go_const && (cnt_bytes > CONST_MAX_BYTES))
                         ? CONST_MAX_BYTES : cnt_bytes;

    wire [1:0] mode     = cmd_reg[1:0];
    wire       acc      = cmd_reg[CMD_ACC_BIT];
    wire       m_upload = (mode == MODE_UPLOAD);
    wire       m_const  = (mode == MODE_DL_CONST);
    wire       nolimit  = count_reg[COUNT_NOLIM_BIT];

    // Byte position: register step every four bytes, lane inside it
    wire [IW-1:0] base_idx = data_reg[IW-1:0];
    wire [IW-1:0] byte_idx = base_idx + ptr_reg[2 +: IW];
    wire [4:0]    lane_sh  = {ptr_reg[1:0], 3'b000};
    wire [7:0]    src_byte = m_const ? data_reg[lane_sh +: 8]
                                     : user_mem[byte_idx][lane_sh +: 8];
    wire          more     = (ptr_reg < limit_reg);

    // Upload bytes beyond the cap are dropped and remembered
    wire ul_take  = xfer && m_upload && ul_valid && more;
    wire ul_extra = xfer && m_upload && ul_valid && !more;
    wire dl_adv   = xfer && !m_upload && (!dl_valid || dl_ready);

    wire timeout_now = xfer && !rsp_valid && tick && (tmo_left_reg <= 16'h0001);
    wire end_now     = xfer && (rsp_valid || timeout_now);
    wire ovf_any     = ovf_reg || ul_extra;
    wire refused     = rsp_abort || (ovf_any && !nolimit);

    wire      flag_upd = end_now || (go && go_bad);
    wire      flag_acc = end_now ? acc : go_acc;
    rda_res_t flag_res;
    assign flag_res = !end_now    ? RES_NEG :
                      timeout_now ? RES_POS :
                      refused     ? RES_NEG :
                                    RES_OK;

    rda_tick #(
        .TICKS   (TICKS)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .restart (go_start),
        .tick    (tick)
    );

    rda_flags u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .upd     (flag_upd),
        .acc     (flag_acc),
        .res     (flag_res),
        .zero_f  (cond_zero),
        .neg_f   (cond_neg),
        .pos_f   (cond_pos)
    );

    // APB slave: one wait state so read data comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && map_err;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration registers; fields stay writable while idle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg     <= CMD_RST;
            data_reg    <= DATA_RST;
            entry_reg   <= ENTRY_RST;
            count_reg   <= COUNT_RST;
            timeout_reg <= TIMEOUT_RST;
        end else if (ce && apb_wr && idle) begin
            if (ofs == OFS_CMD)     cmd_reg     <= pwdata & CMD_MASK;
            if (ofs == OFS_DATA)    data_reg    <= pwdata;
            if (ofs == OFS_ENTRY)   entry_reg   <= pwdata & 32'h00FF_FFFF;
            if (ofs == OFS_COUNT)   count_reg   <= pwdata[15:0];
            if (ofs == OFS_TIMEOUT) timeout_reg <= pwdata[15:0];
        end
    end

    // User register file, no reset: it is data, not control
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (apb_wr && idle && user_hit)
                user_mem[user_idx] <= pwdata;
            else if (ul_take)
                user_mem[byte_idx][lane_sh +: 8] <= ul_byte;
        end
    end

    // Transfer sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= ST_IDLE;
            tmo_left_reg <= 16'h0000;
            ptr_reg      <= 15'h0000;
            limit_reg    <= 15'h0000;
            ovf_reg      <= 1'b0;
        end else if (ce) begin
            case (st_reg)
                ST_IDLE: begin
                    if (go_start) begin
                        st_reg       <= ST_XFER;
                        tmo_left_reg <= timeout_reg;
                        ptr_reg      <= 15'h0000;
                        limit_reg    <= go_limit;
                        ovf_reg      <= 1'b0;
                    end
                end
                ST_XFER: begin
                    if (tick && (tmo_left_reg != 16'h0000))
                        tmo_left_reg <= tmo_left_reg - 16'h0001;
                    if (ul_take || (dl_adv && more))
                        ptr_reg <= ptr_reg + 15'h0001;
                    if (ul_extra)
                        ovf_reg <= 1'b1;
                    if (end_now)
                        st_reg <= ST_IDLE;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // Link outputs; the request is held until the transfer ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_req      <= 1'b0;
            sdo_client   <= 1'b0;
            sdo_upload   <= 1'b0;
            sdo_index    <= 16'h0000;
            sdo_subindex <= 8'h00;
            sdo_size     <= 15'h0000;
            dl_valid     <= 1'b0;
            dl_byte      <= 8'h00;
        end else if (ce) begin
            if (go_start) begin
                sdo_req      <= 1'b1;
                sdo_client   <= (go_client == CLIENT_TWO);
                sdo_upload   <= (go_base == MODE_UPLOAD);
                sdo_index    <= entry_reg[15:0];
                sdo_subindex <= entry_reg[ENTRY_SUB_LSB +: 8];
                sdo_size     <= go_limit;
            end else if (end_now) begin
                sdo_req <= 1'b0;
            end
            if (end_now || !xfer) begin
                dl_valid <= 1'b0;
            end else if (dl_adv) begin
                // Bytes past the byte count are simply never offered
                dl_valid <= more;
                dl_byte  <= more ? src_byte : dl_byte;
            end
        end
    end

    // Result flags after a timeout, an abort and a normal end, byte caps and request lifetime
    a_timeout_pos: assert property (@(posedge pclk) disable iff (!presetn)
        ce && timeout_now && !acc |=> cond_pos && !cond_zero && !cond_neg)
        else $error("timeout did not leave positive only");

    a_abort_neg: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer && rsp_valid && rsp_abort && !acc |=> cond_neg && !cond_pos && !cond_zero)
        else $error("abort did not leave negative only");

    a_ok_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer && rsp_valid && !rsp_abort && !ovf_any && !acc
        |=> cond_zero && !cond_pos && !cond_neg)
        else $error("normal end did not leave zero only");

    a_nolimit_ok: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer && rsp_valid && !rsp_abort && nolimit && !acc |=> cond_zero)
        else $error("truncated string upload was flagged");

    a_acc_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ce && flag_upd && flag_acc && cond_neg |=> cond_neg)
        else $error("accumulated negative flag was lost");

    a_acc_pos: assert property (@(posedge pclk) disable iff (!presetn)
        ce && flag_upd && flag_acc && cond_pos |=> cond_pos)
        else $error("accumulated positive flag was lost");

    a_acc_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && flag_upd && flag_acc && !cond_zero |=> !cond_zero)
        else $error("accumulated zero flag came back");

    a_const_max: assert property (@(posedge pclk) disable iff (!presetn)
        xfer && m_const |-> ptr_reg <= CONST_MAX_BYTES)
        else $error("constant download moved more than four bytes");

    a_cap_held: assert property (@(posedge pclk) disable iff (!presetn)
        xfer |-> ptr_reg <= limit_reg)
        else $error("byte pointer passed the byte count");

    a_req_held: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer && !end_now |=> sdo_req && xfer)
        else $error("request dropped before an ending event");

    a_req_drop: assert property (@(posedge pclk) disable iff (!presetn)
        ce && end_now |=> !sdo_req && idle && !dl_valid)
        else $error("transfer not abandoned at its end");

    // Launch, link pins and byte stream
    a_go_launch: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go_start |=> sdo_req && xfer && (ptr_reg == 15'h0000))
        else $error("valid command did not start a transfer");

    a_upload_dir: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go_start && (go_base == MODE_UPLOAD) |=> sdo_upload)
        else $error("upload command did not request an upload");

    a_bad_neg: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go && go_bad && !go_acc |=> cond_neg && !cond_pos && !cond_zero)
        else $error("invalid command did not leave negative only");

    a_bad_noreq: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go && go_bad |=> !sdo_req && idle)
        else $error("invalid command raised a request");

    a_client_one: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go_start && (go_client == CLIENT_ONE) |=> !sdo_client)
        else $error("client one request used client two");

    a_entry_addr: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go_start |=> (sdo_index == entry_reg[15:0])
            && (sdo_subindex == entry_reg[ENTRY_SUB_LSB +: 8]))
        else $error("request entry differs from entry register");

    a_dl_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer && dl_valid && !dl_ready && !end_now |=> dl_valid && $stable(dl_byte))
        else $error("download byte changed before it was taken");

endmodule

// ===== tb/rda_remote_model.sv
// Behavioural remote dictionary server answering the engine's transfer requests
`timescale 1ns/1ns
module rda_remote_model (
    input  wire logic        pclk,
    input  wire logic        sdo_req,
    input  wire logic        sdo_client,
    input  wire logic        sdo_upload,
    input  wire logic [15:0] sdo_index,
    input  wire logic [7:0]  sdo_subindex,
    input  wire logic        dl_valid,
    input  wire logic [7:0]  dl_byte,
    output logic             dl_ready,
    output logic             ul_valid,
    output logic      [7:0]  ul_byte,
    output logic             rsp_valid,
    output logic             rsp_abort
);
    // Behaviour: 0 answers, 1 refuses, 2 stays silent so the engine must time out
    int          beh    = 0;
    int          n_up   = 0;
    int          narrow = 99;
    bit          slow   = 1'b0;
    int          n_req  = 0;
    logic [7:0]  q[$];
    logic [23:0] got_entry;
    logic [1:0]  got_dir;

    initial begin
        dl_ready  = 1'b0;
        ul_valid  = 1'b0;
        ul_byte   = 8'h00;
        rsp_valid = 1'b0;
        rsp_abort = 1'b0;
        forever begin
            @(posedge pclk);
            if (sdo_req === 1'b1) begin
                // One server serves whichever client the program bound to it
                n_req++;
                q.delete();
                got_entry = {sdo_subindex, sdo_index};
                got_dir   = {sdo_client, sdo_upload};
                if (sdo_upload === 1'b1) begin
                    for (int i = 0; i < n_up; i++) begin
                        ul_valid <= 1'b1;
                        ul_byte  <= 8'hA0 + i[7:0];
                        @(posedge pclk);
                    end
                    ul_valid <= 1'b0;
                    ul_byte  <= ~ul_byte;
                end else begin
                    dl_ready <= 1'b1;
                    repeat (24) begin
                        @(posedge pclk);
                        if (dl_valid === 1'b1 && dl_ready === 1'b1)
                            q.push_back(dl_byte);
                        // A narrow object stops taking bytes once it is full
                        dl_ready <= (q.size() < narrow) && (!slow || !dl_ready);
                    end
                    dl_ready <= 1'b0;
                end
                if (beh != 2) begin
                    rsp_valid <= 1'b1;
                    rsp_abort <= (beh == 1);
                    @(posedge pclk);
                    rsp_valid <= 1'b0;
                    rsp_abort <= 1'b0;
                end
                while (sdo_req === 1'b1) @(posedge pclk);
            end
        end
    end
endmodule

// ===== tb/tb.sv
// Self-checking testbench for the remote dictionary access engine
`timescale 1ns/1ns
module tb
    import rda_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        ce      = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, sdo_req, sdo_client, sdo_upload;
    logic [15:0] sdo_index;
    logic [7:0]  sdo_subindex, dl_byte, ul_byte;
    logic [14:0] sdo_size;
    logic        dl_valid, dl_ready, ul_valid, rsp_valid, rsp_abort;
    logic        cond_zero, cond_neg, cond_pos;
    int          n_errors = 0;
    int          checked  = 0;
    int          req_cyc  = 0;
    int          nq;
    logic [31:0] r;
    logic        e;
    logic [11:0] ofs[5] = '{OFS_CMD, OFS_DATA, OFS_ENTRY, OFS_COUNT, OFS_TIMEOUT};
    logic [31:0] rv[5]  = '{CMD_RST, DATA_RST, ENTRY_RST, {16'h0000, COUNT_RST},
                            {16'h0000, TIMEOUT_RST}};

    rda_top #(.NREG(16), .TICKS(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sdo_req(sdo_req), .sdo_client(sdo_client),
        .sdo_upload(sdo_upload), .sdo_index(sdo_index), .sdo_subindex(sdo_subindex),
        .sdo_size(sdo_size), .dl_valid(dl_valid), .dl_byte(dl_byte), .dl_ready(dl_ready),
        .ul_valid(ul_valid), .ul_byte(ul_byte), .rsp_valid(rsp_valid),
        .rsp_abort(rsp_abort), .cond_zero(cond_zero), .cond_neg(cond_neg),
        .cond_pos(cond_pos));

    rda_remote_model u_rem (
        .pclk(pclk), .sdo_req(sdo_req), .sdo_client(sdo_client), .sdo_upload(sdo_upload),
        .sdo_index(sdo_index), .sdo_subindex(sdo_subindex), .dl_valid(dl_valid),
        .dl_byte(dl_byte), .dl_ready(dl_ready), .ul_valid(ul_valid), .ul_byte(ul_byte),
        .rsp_valid(rsp_valid), .rsp_abort(rsp_abort));

    always #10 pclk = ~pclk;

    always @(posedge pclk) begin
        if (sdo_req === 1'b1)
            req_cyc++;
    end

    task automatic end_sim();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Idle edge first so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (w)
            chk("wr_prdata", prdata, 32'h0000_0000);
        d = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        err;
        apb(1'b1, a, wd, d, err);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic err;
        apb(1'b0, a, 32'h0, d, err);
    endtask

    // Issue a command, poll busy, then compare {pos, neg, zero} in status and on the pins
    task automatic run(input logic [2:0] mode, input logic [1:0] cli, input logic [2:0] exp);
        logic [31:0] s;
        wr(OFS_CMD, {1'b1, 25'h0, cli, 1'b0, mode});
        do begin
            rd(OFS_STATUS, s);
        end while (s[0] !== 1'b0);
        chk("status_flags", {29'h0, s[3:1]}, {29'h0, exp});
        chk("cond_pins", {29'h0, cond_pos, cond_neg, cond_zero}, {29'h0, exp});
    endtask

    task automatic chk_q(input logic [63:0] exp, input int n);
        chk("dl_count", 32'(u_rem.q.size()), 32'(n));
        for (int i = 0; i < n && i < u_rem.q.size(); i++)
            chk("dl_byte", {24'h0, u_rem.q[i]}, {24'h0, exp[8*i +: 8]});
    endtask

    initial begin
        #(20 * 60000);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], r);
            chk("reset_value", r, rv[i]);
        end
        apb(1'b0, 12'h0F0, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        wr(OFS_ENTRY, 32'h0005_2101);
        wr(OFS_TIMEOUT, 32'h0000_0008);
        u_rem.slow = 1'b1;
        wr(OFS_DATA, 32'hDDCC_BBAA);
        wr(OFS_COUNT, 32'h0000_0008);
        run(3'd2, 2'd1, 3'b001);
        chk_q(64'hDDCC_BBAA, 4);
        chk("sdo_size", {17'h0, sdo_size}, 32'h0000_0004);
        chk("entry", {8'h00, u_rem.got_entry}, 32'h0005_2101);
        chk("dir", {30'h0, u_rem.got_dir}, 32'h0);
        u_rem.slow = 1'b0;
        wr(OFS_USER_BASE + 12'h008, 32'h4433_2211);
        wr(OFS_USER_BASE + 12'h00C, 32'h8877_6655);
        wr(OFS_DATA, 32'h0000_0002);
        wr(OFS_COUNT, 32'h0000_0006);
        run(3'd1, 2'd2, 3'b001);
        chk_q(64'h6655_4433_2211, 6);
        chk("dir", {30'h0, u_rem.got_dir}, 32'h2);
        u_rem.narrow = 1;
        wr(OFS_COUNT, 32'h0000_0004);
        run(3'd2, 2'd1, 3'b001);
        chk_q(64'h02, 1);
        u_rem.narrow = 99;
        u_rem.n_up = 6;
        wr(OFS_DATA, 32'h0000_0005);
        wr(OFS_COUNT, 32'h0000_0006);
        run(3'd0, 2'd1, 3'b001);
        chk("dir", {30'h0, u_rem.got_dir}, 32'h1);
        rd(OFS_USER_BASE + 12'h014, r);
        chk("upload_reg5", r, 32'hA3A2_A1A0);
        rd(OFS_USER_BASE + 12'h018, r);
        chk("upload_reg6", {16'h0, r[15:0]}, 32'h0000_A5A4);
        wr(OFS_COUNT, 32'h0000_0002);
        run(3'd0, 2'd1, 3'b010);
        wr(OFS_USER_BASE + 12'h014, 32'h0000_0000);
        wr(OFS_COUNT, 32'h0000_8002);
        run(3'd0, 2'd1, 3'b001);
        rd(OFS_USER_BASE + 12'h014, r);
        chk("trunc_reg5", r, 32'h0000_A1A0);
        u_rem.beh = 1;
        run(3'd1, 2'd1, 3'b010);
        u_rem.beh = 2;
        nq = req_cyc;
        // Freeze 40 cycles mid-wait; the go issued by run lands while busy and is ignored
        wr(OFS_CMD, {1'b1, 25'h0, 2'd1, 1'b0, 3'd0});
        ce <= 1'b0;
        repeat (40) @(posedge pclk);
        ce <= 1'b1;
        run(3'd0, 2'd1, 3'b100);
        nq = req_cyc - nq;
        chk("timeout_len", {31'h0, nq >= 118 && nq <= 123}, 32'h1);
        u_rem.beh = 0;
        nq = u_rem.n_req;
        run(3'd3, 2'd1, 3'b010);
        run(3'd0, 2'd3, 3'b010);
        chk("no_request", 32'(u_rem.n_req), 32'(nq));
        // Accumulated series: plain first, then accumulating refusal and timeout
        u_rem.n_up = 4;
        wr(OFS_COUNT, 32'h0000_0004);
        run(3'd2, 2'd1, 3'b001);
        u_rem.beh = 1;
        run(3'd6, 2'd1, 3'b010);
        u_rem.beh = 2;
        run(3'd4, 2'd1, 3'b110);
        u_rem.beh = 0;
        run(3'd5, 2'd1, 3'b110);
        run(3'd0, 2'd1, 3'b001);
        end_sim();
    end
endmodule
